//--- hw/scs_sequencer.sv
// SAR conversion sequencer: start, switch phases, bit search, result and busy
`timescale 1ns/10ps
`include "scs_defs.svh"
module scs_sequencer
  import scs_pkg::*;
#(
  parameter int CONV_DIV = `SCS_CONV_DIV
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  input wire logic i_convert_start,
  input wire logic i_fast_mode,
  input wire logic i_comp_above,
  output logic o_pos_array_ground_switch,
  output logic o_neg_array_ground_switch,
  output logic o_input_connect,
  output logic o_reference_ground,
  output logic [`SCS_CODE_W-1:0] o_dac_bits,
  output logic o_analog_powered,
  output logic o_busy,
  output logic [`SCS_CODE_W-1:0] o_code,
  output logic o_code_valid,
  output logic o_code_meaningful
);
  localparam int W = `SCS_CODE_W;
  localparam logic [`SCS_PERIOD_W-1:0] FAST_MIN = `SCS_PERIOD_W'(`SCS_FAST_PERIOD_CYC);
  localparam logic [`SCS_PERIOD_W-1:0] NORM_MIN = `SCS_PERIOD_W'(`SCS_NORM_PERIOD_CYC);

  // Elaboration check: a slow conversion clock could not keep up with the fast rate
  if (CONV_DIV * (W + 2) + 2 > `SCS_FAST_PERIOD_CYC) begin : g_div_check
    $error("scs_sequencer: CONV_DIV too slow for the fast rate");
  end

  // Pin synchronisers; logic reads the second stage, and for convert also the delayed copy used for edge detection
  logic cnv_s1_reg, cnv_s2_reg, cnv_prev_reg;
  logic fast_s1_reg, fast_s2_reg;
  logic comp_s1_reg, comp_s2_reg;

  scs_state_t state_reg; // Sequencer phase
  scs_state_t state_next;
  logic [W-1:0] dac_reg; // Trial word driving the element switches
  logic [W-1:0] dac_next;
  logic [W-1:0] mask_reg; // Bit under trial, one-hot
  logic [W-1:0] mask_next;
  logic [W-1:0] code_reg; // Published two's-complement result
  logic valid_reg; // One-cycle completion pulse
  logic meaningful_reg; // Result carries real data
  logic warm_reg; // Fast mode has completed one conversion
  logic [`SCS_PERIOD_W-1:0] period_reg; // Cycles since last accepted start
  logic tick;

  // Decode wires
  logic cnv_rise;
  logic rate_ok;
  logic start;
  logic last_bit;
  logic finish;
  logic [W-1:0] kept;
  logic [W-1:0] result_code;

  scs_conv_clock #(
    .DIV(CONV_DIV)
  ) u_conv_clock (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_ce(i_ce),
    .i_run(state_reg != SCS_ACQ),
    .o_tick(tick)
  );

  // Synchronisers for convert, mode select and comparator
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      cnv_s1_reg <= 1'b0;
      cnv_s2_reg <= 1'b0;
      cnv_prev_reg <= 1'b0;
      fast_s1_reg <= 1'b0;
      fast_s2_reg <= 1'b0;
      comp_s1_reg <= 1'b0;
      comp_s2_reg <= 1'b0;
    end else if (i_ce) begin
      cnv_s1_reg <= i_convert_start;
      cnv_s2_reg <= cnv_s1_reg;
      cnv_prev_reg <= cnv_s2_reg;
      fast_s1_reg <= i_fast_mode;
      fast_s2_reg <= fast_s1_reg;
      comp_s1_reg <= i_comp_above;
      comp_s2_reg <= comp_s1_reg;
    end
  end

  // Start needs a rising edge, acquisition phase and the mode's rate limit
  assign cnv_rise = cnv_s2_reg && !cnv_prev_reg;
  assign rate_ok = period_reg >= (fast_s2_reg ? FAST_MIN : NORM_MIN);
  assign start = cnv_rise && rate_ok && (state_reg == SCS_ACQ);

  // Keep the trial bit when the held input is still above the trial level
  assign kept = comp_s2_reg ? dac_reg : (dac_reg & ~mask_reg);
  assign last_bit = mask_reg[0];
  assign finish = (state_reg == SCS_SEARCH) && tick && last_bit;
  // Offset-binary search word to two's complement; extremes saturate naturally
  assign result_code = {~kept[W-1], kept[W-2:0]};

  // Phase sequencing; every step after start waits for a conversion clock tick
  always_comb begin
    state_next = state_reg;
    dac_next = dac_reg;
    mask_next = mask_reg;
    unique case (state_reg)
      SCS_ACQ: begin
        if (start) begin
          state_next = SCS_OPEN;
        end
      end
      SCS_OPEN: begin
        if (tick) begin
          state_next = SCS_REFERENCE_GROUND;
        end
      end
      SCS_REFERENCE_GROUND: begin
        if (tick) begin
          state_next = SCS_SEARCH;
          dac_next = `SCS_CODE_MSB;
          mask_next = `SCS_CODE_MSB;
        end
      end
      SCS_SEARCH: begin
        if (tick) begin
          if (last_bit) begin
            state_next = SCS_ACQ;
            dac_next = '0;
            mask_next = '0;
          end else begin
            dac_next = kept | (mask_reg >> 1);
            mask_next = mask_reg >> 1;
          end
        end
      end
    endcase
  end

  // Phase, trial word and rate counter
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_reg <= SCS_ACQ;
      dac_reg <= '0;
      mask_reg <= '0;
      period_reg <= '1;
    end else if (i_ce) begin
      state_reg <= state_next;
      dac_reg <= dac_next;
      mask_reg <= mask_next;
      if (start) begin
        period_reg <= `SCS_PERIOD_W'(1);
      end else if (period_reg != '1) begin
        period_reg <= period_reg + `SCS_PERIOD_W'(1);
      end
    end
  end

  // Result publication; code replaced only by the conversion just finished
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      code_reg <= `SCS_CODE_ZERO;
      valid_reg <= 1'b0;
      meaningful_reg <= 1'b0;
      warm_reg <= 1'b0;
    end else if (i_ce) begin
      valid_reg <= finish;
      if (finish) begin
        code_reg <= result_code;
        meaningful_reg <= !fast_s2_reg || warm_reg;
      end
      // Leaving fast mode means a power-down, so the next fast start is cold
      if (!fast_s2_reg) begin
        warm_reg <= 1'b0;
      end else if (finish) begin
        warm_reg <= 1'b1;
      end
    end
  end

  // Switch controls decoded from the phase; ground switches closed only in acquisition
  assign o_pos_array_ground_switch = (state_reg == SCS_ACQ);
  assign o_neg_array_ground_switch = (state_reg == SCS_ACQ);
  assign o_input_connect = (state_reg == SCS_ACQ) || (state_reg == SCS_OPEN);
  assign o_reference_ground = (state_reg == SCS_REFERENCE_GROUND) || (state_reg == SCS_SEARCH);
  assign o_dac_bits = dac_reg;
  assign o_busy = (state_reg != SCS_ACQ);
  assign o_analog_powered = fast_s2_reg || (state_reg != SCS_ACQ);
  assign o_code = code_reg;
  assign o_code_valid = valid_reg;
  assign o_code_meaningful = meaningful_reg;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst || !i_ce);

  sequence s_grounds_open;
    !o_pos_array_ground_switch && !o_neg_array_ground_switch && o_input_connect;
  endsequence
  sequence s_on_reference_ground;
    !o_input_connect && o_reference_ground;
  endsequence

  property p_start_edge;
    $rose(o_busy) |-> $past(cnv_rise) && ($past(state_reg) == SCS_ACQ);
  endproperty
  a_start_edge: assert property (p_start_edge) else $error("busy rose without edge");

  property p_switch_order;
    start |=> s_grounds_open [*3] ##1 s_on_reference_ground;
  endproperty
  a_switch_order: assert property (p_switch_order) else $error("switch order wrong");

  property p_msb_first;
    $rose(state_reg == SCS_SEARCH) |-> (o_dac_bits == 18'h20000);
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("search not msb first");

  property p_done;
    o_code_valid |-> !o_busy && o_pos_array_ground_switch && o_input_connect;
  endproperty
  a_done: assert property (p_done) else $error("not back in acquisition");

  property p_tick_paced;
    (state_reg == SCS_SEARCH) && !tick |=> $stable(mask_reg);
  endproperty
  a_tick_paced: assert property (p_tick_paced) else $error("step without tick");

  property p_fast_power;
    fast_s2_reg |-> o_analog_powered;
  endproperty
  a_fast_power: assert property (p_fast_power) else $error("fast mode powered down");

  property p_norm_rate;
    start && !fast_s2_reg |-> period_reg >= NORM_MIN;
  endproperty
  a_norm_rate: assert property (p_norm_rate) else $error("normal rate exceeded");

  property p_norm_sleep;
    !fast_s2_reg && !o_busy |-> !o_analog_powered;
  endproperty
  a_norm_sleep: assert property (p_norm_sleep) else $error("normal mode stays powered");

  property p_norm_valid;
    o_code_valid && !$past(fast_s2_reg) |-> o_code_meaningful;
  endproperty
  a_norm_valid: assert property (p_norm_valid) else $error("normal result flagged bad");

  property p_saturate_pos;
    finish && (kept == '1) |=> (o_code == 18'h1ffff);
  endproperty
  a_saturate_pos: assert property (p_saturate_pos) else $error("positive full code wrong");

  property p_saturate_neg;
    finish && (kept == '0) |=> (o_code == 18'h20000);
  endproperty
  a_saturate_neg: assert property (p_saturate_neg) else $error("negative full code wrong");

  property p_busy_span;
    start |=> o_busy ##[50:80] o_code_valid;
  endproperty
  a_busy_span: assert property (p_busy_span) else $error("busy span wrong");
endmodule

//--- pkg/scs_defs.svh
// Constants of the SAR conversion sequencer: widths, codes and timing counts
// Summary of operation
// - Convert rising edge after acquisition starts conversion
// - Open ground switches, then arrays to reference ground
// - Eighteen-step binary search, most significant first
// - Finish: back to acquisition, code, busy drops
// - Steps paced by internal conversion clock only
// - Fast mode: up to 2 MSPS, stays powered
// - Normal mode: at most 1.5 MSPS, powers down
// - First normal-mode result is already valid
// - Two's-complement code, zero is all zeros
// - Largest code 0x1ffff, overrange saturates there
// - Smallest code 0x20000, underrange saturates there
// - Code belongs to the latest accepted convert edge
`ifndef SCS_DEFS_SVH
`define SCS_DEFS_SVH
`define SCS_CODE_W 18
`define SCS_CODE_MSB 18'h20000
`define SCS_CODE_ZERO 18'h00000
`define SCS_CODE_POS_FULL 18'h1ffff
`define SCS_CODE_NEG_FULL 18'h20000
`define SCS_CLK_KHZ 125000
`define SCS_FAST_RATE_KSPS 2000
`define SCS_NORM_RATE_KSPS 1500
`define SCS_FAST_PERIOD_CYC ((`SCS_CLK_KHZ + `SCS_FAST_RATE_KSPS - 1) / `SCS_FAST_RATE_KSPS)
`define SCS_NORM_PERIOD_CYC ((`SCS_CLK_KHZ + `SCS_NORM_RATE_KSPS - 1) / `SCS_NORM_RATE_KSPS)
`define SCS_CONV_DIV 3
`define SCS_PERIOD_W 8
`endif

//--- pkg/scs_pkg.sv
// Types shared by the SAR conversion sequencer
package scs_pkg;
  typedef enum logic [1:0] {
    SCS_ACQ,
    SCS_OPEN,
    SCS_REFERENCE_GROUND,
    SCS_SEARCH
  } scs_state_t;
endpackage

//--- hw/scs_conv_clock.sv
// Internal conversion clock: tick generator restarted at each conversion
`timescale 1ns/10ps
module scs_conv_clock #(
  parameter int DIV = 3
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  input wire logic i_run,
  output logic o_tick
);
  localparam int CW = $clog2(DIV + 1);

  logic [CW-1:0] cnt_reg; // Cycles since last tick
  logic [CW-1:0] cnt_next;
  logic at_end;

  // Elaboration check: a shorter period leaves the synced comparator no time to settle
  if (DIV < 3) begin : g_div_check
    $error("scs_conv_clock: DIV must be at least 3");
  end

  // Tick on the last cycle of each period; restart keeps steps aligned to start
  assign at_end = (cnt_reg == CW'(DIV - 1));
  assign cnt_next = at_end ? '0 : cnt_reg + CW'(1);
  assign o_tick = i_run && at_end;

  // Counter runs only while a conversion is under way
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      cnt_reg <= '0;
    end else if (i_ce) begin
      cnt_reg <= i_run ? cnt_next : '0;
    end
  end
endmodule

//--- test/scs_comp_model.sv
// Comparator model at the far side: holds the sampled level and judges trial words
`timescale 1ns/10ps
`include "scs_defs.svh"
module scs_comp_model (
  input wire logic i_clk,
  input wire logic [`SCS_CODE_W-1:0] i_level, // Offset-binary input level
  input wire logic i_input_connect,
  input wire logic i_reference_ground,
  input wire logic [`SCS_CODE_W-1:0] i_dac_bits,
  output logic o_comp_above
);
  logic [`SCS_CODE_W-1:0] held_reg; // Charge kept on the arrays
  logic junk_reg = 1'b0; // Toggles so an idle comparator never looks steady
  // Track the input only while the arrays are connected to it
  always @(posedge i_clk) begin
    if (i_input_connect) begin
      held_reg <= i_level;
    end
    junk_reg <= ~junk_reg;
  end
  // Only a reference-grounded array gives a meaningful decision
  assign o_comp_above = i_reference_ground ? (held_reg >= i_dac_bits) : junk_reg;
endmodule

//--- test/tb.sv
// Self-checking testbench of the SAR conversion sequencer
`timescale 1ns/10ps
module tb;
  localparam int DIV = 3;
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic convert_start = 1'b0; // Convert pin
  logic fast = 1'b0; // Fast-mode pin
  logic ce = 1'b1; // Clock enable, dropped briefly inside each conversion
  logic [17:0] level = 18'h00000; // Analog level seen by the comparator model
  logic comp, pos_sw, neg_sw, in_con, ref_gnd, powered, busy, vld, mean;
  logic [17:0] dac, code;
  logic [18:0] exp_q[$]; // Expected {meaningful, code} in issue order
  logic [18:0] exp_e;
  logic warm = 1'b0; // Host view: fast mode already produced one result
  int n_mismatch = 0;
  int checked = 0;
  int seed = 27682;
  always #4 i_clk = ~i_clk;
  scs_sequencer #(.CONV_DIV(DIV)) u_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(ce),
    .i_convert_start(convert_start), .i_fast_mode(fast), .i_comp_above(comp),
    .o_pos_array_ground_switch(pos_sw), .o_neg_array_ground_switch(neg_sw),
    .o_input_connect(in_con), .o_reference_ground(ref_gnd), .o_dac_bits(dac),
    .o_analog_powered(powered), .o_busy(busy), .o_code(code), .o_code_valid(vld),
    .o_code_meaningful(mean));
  scs_comp_model u_comp (.i_clk(i_clk), .i_level(level), .i_input_connect(in_con),
    .i_reference_ground(ref_gnd), .i_dac_bits(dac), .o_comp_above(comp));
  // Compare one value and count it
  task automatic chk(input string name, input logic [17:0] got, input logic [17:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Print counts and verdict, then stop
  task automatic complete_run();
    $display("Comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // One conversion as the host runs it, with a refused edge in mid-conversion
  task automatic conv(input logic [17:0] lvl, input logic f);
    int n;
    logic m;
    if (f !== fast) begin
      fast = f;
      repeat (4) @(negedge i_clk);
    end
    m = !f || warm; // First fast result must be flagged for discarding
    level = lvl;
    convert_start = 1'b1;
    n = 0;
    while (busy !== 1'b1) begin
      @(negedge i_clk);
      n++;
      if (n > 10) begin
        n_mismatch++;
        $display("[FAIL] busy_start expected 1 seen 0");
        complete_run();
      end
    end
    exp_q.push_back({m, lvl ^ 18'h20000});
    chk("phase_open", 18'({pos_sw, neg_sw, in_con, ref_gnd}), 18'h00002);
    chk("busy_power", 18'(powered), 18'h00001);
    repeat (DIV) @(negedge i_clk);
    chk("phase_reference_ground", 18'({pos_sw, neg_sw, in_con, ref_gnd}), 18'h00001);
    convert_start = 1'b0;
    level = ~lvl; // Input moves after sampling; result must not follow it
    repeat (4) @(negedge i_clk);
    convert_start = 1'b1; // Edge while busy is ignored
    ce = 1'b0; // Frozen cycles must stretch busy without touching the result
    repeat (2) @(negedge i_clk);
    ce = 1'b1;
    n = DIV + 7;
    while (busy === 1'b1 && n < 200) begin
      @(negedge i_clk);
      if (busy === 1'b1) begin
        n++;
      end
    end
    chk("busy_len", 18'(n), 18'(20 * DIV + 2));
    convert_start = 1'b0;
    repeat (30) @(negedge i_clk);
    chk("idle_state", 18'({pos_sw, neg_sw, in_con, ref_gnd}), 18'h0000e);
    chk("idle_dac", dac, 18'h00000);
    chk("powered", 18'(powered), 18'(f));
    warm = f;
  endtask
  // Result watcher: samples mid-cycle, so each valid pulse is seen once and settled
  always @(negedge i_clk) begin
    if (vld === 1'b1) begin
      if (exp_q.size() == 0) begin
        n_mismatch++;
        $display("[FAIL] code_valid expected 0 seen 1");
      end else begin
        exp_e = exp_q.pop_front();
        chk("code", code, exp_e[17:0]);
        chk("meaningful", 18'(mean), 18'(exp_e[18]));
      end
    end
  end
  // Main sequence
  initial begin
    logic [17:0] tbl[6];
    tbl = '{18'h20000, 18'h20001, 18'h1ffff, 18'h3ffff, 18'h00000, 18'h00001};
    repeat (5) @(posedge i_clk);
    @(negedge i_clk);
    i_sys_rst = 1'b0;
    chk("reset_ctl", 18'({busy, vld, mean, ref_gnd, in_con, pos_sw, neg_sw}), 18'h00007);
    chk("reset_code", code, 18'h00000);
    // Normal-mode codes at zero, one step either side and both saturation ends
    foreach (tbl[i]) begin
      conv(tbl[i], 1'b0);
    end
    conv(18'h2a5a5, 1'b1);
    conv(18'h15a5a, 1'b1);
    // Reset between conversions clears the result and the fast-mode history
    i_sys_rst = 1'b1;
    repeat (2) @(negedge i_clk);
    i_sys_rst = 1'b0;
    warm = 1'b0;
    chk("rerun_code", code, 18'h00000);
    chk("rerun_mean", 18'(mean), 18'h00000);
    conv(18'h2a5a5, 1'b1);
    // Random levels and modes, including re-entries into fast mode
    repeat (8) begin
      conv(18'($random(seed)), 1'($random(seed)));
    end
    repeat (100) @(negedge i_clk);
    chk("pending", 18'(exp_q.size()), 18'h00000);
    complete_run();
  end
endmodule
